// ===== src/spisp_port.sv
// Framed serial peripheral port: master or slave shift engine with buffers

// ****************************************************************
// Port
// ****************************************************************
module spisp_port (
  input  wire logic               i_ref_clk,
  input  wire logic               i_sys_rst,
  input  wire logic               i_clk_en,
  input  wire spisp_pkg::spisp_cfg_t i_cfg,
  input  wire logic               i_sleep,
  input  wire logic               i_transfer_done_irq_enable,
  input  wire logic               i_buf_wr,
  input  wire logic [15:0]        i_buf_wdata,
  input  wire logic               i_buf_rd,
  input  wire logic               i_ovf_clear,
  input  wire logic               i_irq_flag_clear,
  input  wire logic               i_serial_data_in_pin,
  input  wire logic               i_shift_clock_pin,
  input  wire logic               i_slave_select_n_pin,
  output logic [15:0]             o_rx_data,
  output logic                    o_rx_full,
  output logic                    o_tx_full,
  output logic                    o_receive_overflow_flag,
  output logic                    o_transfer_done_irq_flag,
  output logic                    o_irq,
  output logic                    o_serial_data_out_pin,
  output logic                    o_serial_data_out_oe_n,
  output logic                    o_shift_clock_pin,
  output logic                    o_shift_clock_oe_n,
  output logic                    o_slave_select_n_pin,
  output logic                    o_slave_select_oe_n
);

  // ****************************************************************
  // State
  // ****************************************************************
  spisp_pkg::spisp_state_t             state_q;
  logic [spisp_pkg::CNT_W-1:0]         bitcnt_q;
  logic [spisp_pkg::DIV_W-1:0]         div_cnt_q;
  logic [spisp_pkg::WORD_W-1:0]        shreg_q;
  logic [spisp_pkg::WORD_W-1:0]        txbuf_q;
  logic [spisp_pkg::WORD_W-1:0]        rxbuf_q;
  logic                                tx_full_q;
  logic                                rx_full_q;
  logic                                ovf_q;
  logic                                irq_flag_q;
  logic                                irq_q;
  logic                                sck_q;
  logic                                sck_in_q;
  logic                                sdo_q;
  logic                                sdo_oe_n_q;
  logic                                sck_oe_n_q;
  logic                                fs_q;
  logic                                fs_oe_n_q;
  logic                                width_q;

  // ****************************************************************
  // Edge decode
  // ****************************************************************
  logic                         master;
  logic                         framed;
  logic                         fs_out_dir;
  logic                         mode_chg;
  logic                         desel;
  logic                         abort;
  logic                         running;
  logic                         tick;
  logic                         edge_ev;
  logic                         leading;
  logic                         sample_ev;
  logic                         shift_ev;
  logic                         last_ev;
  logic                         end_ev;
  logic                         go;
  logic                         ovf_hit;
  logic [spisp_pkg::CNT_W-1:0]  nbits;
  logic [spisp_pkg::DIV_W-1:0]  half;
  logic [spisp_pkg::WORD_W-1:0] captured;
  logic [spisp_pkg::WORD_W-1:0] load_word;

  assign master     = i_cfg.master_mode;
  assign framed     = i_cfg.framed_mode_enable;
  // Direction bit low means this end makes the frame pulse
  assign fs_out_dir = framed & ~i_cfg.frame_sync_direction;
  assign nbits      = i_cfg.word_width_select ? spisp_pkg::BITS_16 : spisp_pkg::BITS_8;
  assign mode_chg   = i_cfg.word_width_select != width_q;
  assign desel      = ~master & ~framed & i_cfg.slave_select_enable
                    & i_slave_select_n_pin;
  assign abort      = ~i_cfg.enable | i_sleep | mode_chg | desel;
  // Overflow freezes the engine including the master clock
  assign running    = (state_q != spisp_pkg::ST_IDLE) & ~ovf_q & ~abort;
  assign half       = spisp_pkg::half_period(i_cfg.primary_prescale_sel,
                                             i_cfg.secondary_prescale_sel);
  assign tick       = master & running & (div_cnt_q == half - spisp_pkg::DIV_ONE);
  // A slave pin must hold each level one enabled clock or one of its edges is lost
  assign edge_ev    = running & (master ? tick : (i_shift_clock_pin != sck_in_q));
  assign leading    = master ? (sck_q == i_cfg.clock_idle_polarity)
                             : (sck_in_q == i_cfg.clock_idle_polarity);
  // Edge bit high: sample going active, change going idle
  assign sample_ev  = edge_ev & (leading == i_cfg.clock_edge_sel);
  assign shift_ev   = sample_ev & (state_q == spisp_pkg::ST_SHIFT) & (bitcnt_q < nbits);
  assign last_ev    = shift_ev & (bitcnt_q == nbits - spisp_pkg::CNT_ONE);
  assign end_ev     = edge_ev & ~leading & (state_q == spisp_pkg::ST_SHIFT)
                    & ((bitcnt_q == nbits) | last_ev);
  assign captured   = {shreg_q[spisp_pkg::WORD_W-2:0], i_serial_data_in_pin};
  // A read in the same cycle frees the buffer for the new word
  assign ovf_hit    = last_ev & rx_full_q & ~i_buf_rd;
  assign go         = (state_q == spisp_pkg::ST_IDLE) & ~abort & ~ovf_q
                    & (master ? tx_full_q : 1'b1);
  assign load_word  = tx_full_q ? txbuf_q : shreg_q;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q  <= spisp_pkg::ST_IDLE;
      bitcnt_q <= spisp_pkg::CNT_RST;
      width_q  <= 1'b0;
    end else if (i_clk_en) begin
      width_q <= i_cfg.word_width_select;
      // Abort wins over every state, so sleep, deselect and a width change
      // all make the next word start again at its top bit
      if (abort) begin
        state_q  <= spisp_pkg::ST_IDLE;
        bitcnt_q <= spisp_pkg::CNT_RST;
      end else begin
        case (state_q)
          spisp_pkg::ST_IDLE: begin
            bitcnt_q <= spisp_pkg::CNT_RST;
            if (go) begin
              state_q <= framed ? spisp_pkg::ST_SYNC : spisp_pkg::ST_SHIFT;
            end
          end
          spisp_pkg::ST_SYNC: begin
            // Pulse, driven or received, is checked high on the trailing edge of its clock
            if (edge_ev & ~leading) begin
              if (fs_out_dir ? fs_q : i_slave_select_n_pin) begin
                state_q <= spisp_pkg::ST_SHIFT;
              end
            end
          end
          spisp_pkg::ST_SHIFT: begin
            if (shift_ev) begin
              bitcnt_q <= bitcnt_q + spisp_pkg::CNT_ONE;
            end
            if (end_ev) begin
              state_q <= spisp_pkg::ST_IDLE;
            end
          end
          default: begin
            state_q <= spisp_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Shift register and data output
  // ****************************************************************
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shreg_q <= spisp_pkg::DATA_RST;
      sdo_q   <= 1'b0;
    end else if (i_clk_en) begin
      // A new word loads whole, so a restart begins at its top bit
      if (go) begin
        shreg_q <= load_word;
        sdo_q   <= spisp_pkg::out_bit(load_word, i_cfg.word_width_select);
      end else if (shift_ev) begin
        shreg_q <= captured;
      end else if (edge_ev & ~sample_ev & (state_q == spisp_pkg::ST_SHIFT)) begin
        sdo_q <= spisp_pkg::out_bit(shreg_q, i_cfg.word_width_select);
      end
    end
  end

  // ****************************************************************
  // Transmit and receive buffers
  // ****************************************************************
  // A width change empties both buffers but keeps their contents
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      txbuf_q   <= spisp_pkg::DATA_RST;
      tx_full_q <= 1'b0;
    end else if (i_clk_en) begin
      if (mode_chg) begin
        tx_full_q <= 1'b0;
      end else if (i_buf_wr) begin
        txbuf_q   <= i_buf_wdata;
        tx_full_q <= 1'b1;
      end else if (go & tx_full_q) begin
        tx_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rxbuf_q   <= spisp_pkg::DATA_RST;
      rx_full_q <= 1'b0;
    end else if (i_clk_en) begin
      if (mode_chg) begin
        rx_full_q <= 1'b0;
      end else if (last_ev & ~ovf_hit) begin
        rxbuf_q   <= spisp_pkg::rx_word(captured, i_cfg.word_width_select);
        rx_full_q <= 1'b1;
      end else if (i_buf_rd) begin
        rx_full_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Flags
  // ****************************************************************
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ovf_q <= 1'b0;
    end else if (i_clk_en) begin
      // Set beats clear: a word lost in the clear cycle must still be flagged
      if (ovf_hit) begin
        ovf_q <= 1'b1;
      end else if (mode_chg | i_buf_rd | i_ovf_clear) begin
        ovf_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_flag_q <= 1'b0;
      irq_q      <= 1'b0;
    end else if (i_clk_en) begin
      if (last_ev) begin
        irq_flag_q <= 1'b1;
      end else if (i_irq_flag_clear) begin
        irq_flag_q <= 1'b0;
      end
      irq_q <= irq_flag_q & i_transfer_done_irq_enable;
    end
  end

  // ****************************************************************
  // Master clock generation
  // ****************************************************************
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_cnt_q <= spisp_pkg::DIV_RST;
      sck_q     <= 1'b0;
      sck_in_q  <= 1'b0;
    end else if (i_clk_en) begin
      sck_in_q <= i_shift_clock_pin;
      if (~running) begin
        // Hold count while frozen by overflow so the clock resumes mid bit
        if (~ovf_q | abort) begin
          div_cnt_q <= spisp_pkg::DIV_RST;
        end
        // Any abort parks the clock at once, so a sleeping port shows idle
        if ((state_q == spisp_pkg::ST_IDLE) | abort) begin
          sck_q <= i_cfg.clock_idle_polarity;
        end
      end else if (tick) begin
        div_cnt_q <= spisp_pkg::DIV_RST;
        sck_q     <= ~sck_q;
      end else begin
        div_cnt_q <= div_cnt_q + spisp_pkg::DIV_ONE;
      end
    end
  end

  // ****************************************************************
  // Frame sync output
  // ****************************************************************
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fs_q <= 1'b0;
    end else if (i_clk_en) begin
      // Only the driving end makes the pulse; a receiving end reads the pin
      if (abort | ~fs_out_dir) begin
        fs_q <= 1'b0;
      end else if (edge_ev & leading) begin
        // High from the leading edge of the sync clock to the next one
        fs_q <= (state_q == spisp_pkg::ST_SYNC);
      end
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sdo_oe_n_q <= 1'b1;
      sck_oe_n_q <= 1'b1;
      fs_oe_n_q  <= 1'b1;
    end else if (i_clk_en) begin
      // Output disable drops only the enable; the data flop keeps shifting
      sdo_oe_n_q <= ~(i_cfg.enable & ~i_sleep & ~i_cfg.data_out_disable & ~desel);
      sck_oe_n_q <= ~(i_cfg.enable & master);
      fs_oe_n_q  <= ~(i_cfg.enable & fs_out_dir);
    end
  end

  assign o_rx_data                = rxbuf_q;
  assign o_rx_full                = rx_full_q;
  assign o_tx_full                = tx_full_q;
  assign o_receive_overflow_flag  = ovf_q;
  assign o_transfer_done_irq_flag = irq_flag_q;
  assign o_irq                    = irq_q;
  assign o_serial_data_out_pin    = sdo_q;
  assign o_serial_data_out_oe_n   = sdo_oe_n_q;
  assign o_shift_clock_pin        = sck_q;
  assign o_shift_clock_oe_n       = sck_oe_n_q;
  assign o_slave_select_n_pin     = fs_q;
  assign o_slave_select_oe_n      = fs_oe_n_q;

endmodule : spisp_port

// ===== src/spisp_pkg.sv
// Shared constants, types and helper functions of the framed serial peripheral port
package spisp_pkg;

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int unsigned      WORD_W   = 16;
  localparam int unsigned      BYTE_W   = 8;
  localparam int unsigned      CNT_W    = 5;
  localparam int unsigned      DIV_W    = 11;
  localparam int unsigned      MSB_8    = 7;
  localparam int unsigned      MSB_16   = 15;
  localparam int unsigned      LSB_IN   = 0;
  localparam logic [WORD_W-1:0] DATA_RST = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_RST  = 5'h00;
  localparam logic [CNT_W-1:0]  CNT_ONE  = 5'h01;
  localparam logic [CNT_W-1:0]  BITS_8   = 5'h08;
  localparam logic [CNT_W-1:0]  BITS_16  = 5'h10;

  // ****************************************************************
  // Clock division: reference clock over four, then two prescalers
  // ****************************************************************
  localparam logic [DIV_W-1:0] FOSC_DIV  = 11'h004;
  localparam logic [DIV_W-1:0] FOSC_HALF = FOSC_DIV >> 1;
  localparam logic [DIV_W-1:0] DIV_RST   = 11'h000;
  localparam logic [DIV_W-1:0] DIV_ONE   = 11'h001;
  localparam logic [DIV_W-1:0] PRI_DIV_0 = 11'h040;
  localparam logic [DIV_W-1:0] PRI_DIV_1 = 11'h010;
  localparam logic [DIV_W-1:0] PRI_DIV_2 = 11'h004;
  localparam logic [DIV_W-1:0] PRI_DIV_3 = 11'h001;
  localparam logic [DIV_W-1:0] SEC_BASE  = 11'h008;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_SYNC  = 2'h1,
    ST_SHIFT = 2'h3
  } spisp_state_t;

  typedef struct packed {
    logic       enable;
    logic       master_mode;
    logic       clock_idle_polarity;
    logic       clock_edge_sel;
    logic       word_width_select;
    logic       data_out_disable;
    logic       framed_mode_enable;
    logic       frame_sync_direction;
    logic       slave_select_enable;
    logic [1:0] primary_prescale_sel;
    logic [2:0] secondary_prescale_sel;
  } spisp_cfg_t;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Shift clock half period in reference clocks
  function automatic logic [DIV_W-1:0] half_period(input logic [1:0] pri_sel,
                                                   input logic [2:0] sec_sel);
    logic [DIV_W-1:0] pri;
    logic [DIV_W-1:0] sec;
    case (pri_sel)
      2'h0:    pri = PRI_DIV_0;
      2'h1:    pri = PRI_DIV_1;
      2'h2:    pri = PRI_DIV_2;
      default: pri = PRI_DIV_3;
    endcase
    sec = SEC_BASE - {{(DIV_W-3){1'b0}}, sec_sel};
    return DIV_W'(pri * sec * FOSC_HALF);
  endfunction : half_period

  function automatic logic out_bit(input logic [WORD_W-1:0] v, input logic w16);
    return w16 ? v[MSB_16] : v[MSB_8];
  endfunction : out_bit

  function automatic logic [WORD_W-1:0] rx_word(input logic [WORD_W-1:0] v,
                                                input logic w16);
    return w16 ? v : {{(WORD_W-BYTE_W){1'b0}}, v[BYTE_W-1:0]};
  endfunction : rx_word

endpackage : spisp_pkg

// ===== tb/spisp_port_chk.sv
// Concurrent checks on the serial port pins and software flags
module spisp_port_chk (
  input wire logic                  i_ref_clk,
  input wire logic                  i_sys_rst,
  input wire logic                  i_clk_en,
  input wire spisp_pkg::spisp_cfg_t i_cfg,
  input wire logic                  i_sleep,
  input wire logic                  i_transfer_done_irq_enable,
  input wire logic                  i_buf_wr,
  input wire logic                  i_buf_rd,
  input wire logic [15:0]           o_rx_data,
  input wire logic                  o_rx_full,
  input wire logic                  o_tx_full,
  input wire logic                  o_receive_overflow_flag,
  input wire logic                  o_transfer_done_irq_flag,
  input wire logic                  o_irq,
  input wire logic                  o_serial_data_out_oe_n,
  input wire logic                  o_shift_clock_pin,
  input wire logic                  o_shift_clock_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // ****************************************************************
  // Word completion steps
  // ****************************************************************
  sequence s_word_done;
    $rose(o_transfer_done_irq_flag);
  endsequence
  sequence s_word_stored;
    o_rx_full || o_receive_overflow_flag;
  endsequence
  chk_irq_follows: assert property (
    i_clk_en && o_transfer_done_irq_flag && i_transfer_done_irq_enable |=> o_irq)
    else $error("irq missing after done flag");
  chk_irq_gated: assert property (
    i_clk_en && !i_transfer_done_irq_enable |=> !o_irq) else $error("irq while disabled");
  chk_write_held: assert property (
    i_clk_en && i_buf_wr |=> o_tx_full) else $error("write not held");
  chk_word_stored: assert property (
    s_word_done |=> s_word_stored) else $error("finished word not stored");
  chk_read_clears: assert property (
    i_clk_en && i_buf_rd && i_cfg.master_mode ##1 $stable(o_shift_clock_pin)
    |-> !o_receive_overflow_flag) else $error("overflow kept after read");
  chk_out_disable: assert property (
    (i_clk_en && i_cfg.data_out_disable)[*2] |-> o_serial_data_out_oe_n)
    else $error("data output driven while disabled");
  chk_clock_driven: assert property (
    (i_clk_en && i_cfg.master_mode && i_cfg.enable)[*2] |-> !o_shift_clock_oe_n)
    else $error("master clock not driven");
  chk_sleep_parks: assert property (
    (i_clk_en && i_sleep && i_cfg.master_mode && $stable(i_cfg.clock_idle_polarity))[*2]
    |-> o_shift_clock_pin == i_cfg.clock_idle_polarity) else $error("clock not parked");
  chk_byte_upper: assert property (
    $rose(o_rx_full) && !i_cfg.word_width_select |-> o_rx_data[15:8] == 8'h00)
    else $error("upper byte not zero");
endmodule : spisp_port_chk

bind spisp_port spisp_port_chk spisp_port_chk_inst (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_cfg(i_cfg),
  .i_sleep(i_sleep), .i_transfer_done_irq_enable(i_transfer_done_irq_enable),
  .i_buf_wr(i_buf_wr), .i_buf_rd(i_buf_rd), .o_rx_data(o_rx_data), .o_rx_full(o_rx_full),
  .o_tx_full(o_tx_full), .o_receive_overflow_flag(o_receive_overflow_flag),
  .o_transfer_done_irq_flag(o_transfer_done_irq_flag), .o_irq(o_irq),
  .o_serial_data_out_oe_n(o_serial_data_out_oe_n), .o_shift_clock_pin(o_shift_clock_pin),
  .o_shift_clock_oe_n(o_shift_clock_oe_n));

// ===== tb/spisp_far_model.sv
// Behavioural far-side partner clocked by whichever end owns the shift clock
module spisp_far_model (
  input  wire logic        i_sck,
  input  wire logic        i_mosi,
  input  wire logic        i_w16,
  input  wire logic        i_fs,
  input  wire logic        i_load,
  input  wire logic [15:0] i_word,
  output logic             o_miso,
  output logic [15:0]      o_got
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] sh_q = 16'h0000;
  initial o_got = 16'h0000;
  always @(posedge i_load) sh_q = i_word;
  always @(posedge i_sck) o_got = {o_got[14:0], i_mosi};
  // Spent bits come back inverted so a stale line never looks valid
  // The sync clock of a framed word carries no data, so the word holds
  always @(negedge i_sck) begin
    if (!i_fs) begin
      sh_q = {sh_q[14:0], ~sh_q[15]};
    end
  end
  assign o_miso = i_w16 ? sh_q[15] : sh_q[7];
endmodule : spisp_far_model

// ===== tb/tb_spisp_port.sv
// Self-checking bench: the port as master and as slave against a behavioural partner
module tb_spisp_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic                  i_ref_clk = 1'b0;
  logic                  i_sys_rst = 1'b1;
  logic                  clk_en    = 1'b1;
  logic                  sleep     = 1'b0;
  logic                  irq_en    = 1'b1;
  logic                  wr        = 1'b0;
  logic                  rd        = 1'b0;
  logic                  ovf_clr   = 1'b0;
  logic                  flag_clr  = 1'b0;
  logic                  far_load  = 1'b0;
  logic [15:0]           wdata     = 16'h0000;
  logic [15:0]           far_word  = 16'h0000;
  logic                  sck_in    = 1'b0;
  logic                  ss_n      = 1'b1;
  spisp_pkg::spisp_cfg_t cfg       = '0;
  logic [15:0]           rx_data, far_got;
  logic                  rx_full, tx_full, ovf, done, irq, sdo, sdo_oe_n, sck, miso;
  logic                  fs, fs_oe_n;
  int                    failures  = 0;
  int                    compares  = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  spisp_port spisp_port_inst (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_clk_en(clk_en), .i_cfg(cfg),
    .i_sleep(sleep), .i_transfer_done_irq_enable(irq_en), .i_buf_wr(wr),
    .i_buf_wdata(wdata), .i_buf_rd(rd), .i_ovf_clear(ovf_clr), .i_irq_flag_clear(flag_clr),
    .i_serial_data_in_pin(miso), .i_shift_clock_pin(sck_in), .i_slave_select_n_pin(ss_n),
    .o_rx_data(rx_data), .o_rx_full(rx_full), .o_tx_full(tx_full),
    .o_receive_overflow_flag(ovf), .o_transfer_done_irq_flag(done), .o_irq(irq),
    .o_serial_data_out_pin(sdo), .o_serial_data_out_oe_n(sdo_oe_n),
    .o_shift_clock_pin(sck), .o_shift_clock_oe_n(), .o_slave_select_n_pin(fs),
    .o_slave_select_oe_n(fs_oe_n));
  // A released data line shows the inverse so a stale bit never looks valid
  spisp_far_model spisp_far_model_inst (
    .i_sck(cfg.master_mode ? sck : sck_in), .i_mosi(sdo_oe_n ? ~sdo : sdo),
    .i_w16(cfg.word_width_select), .i_fs(fs), .i_load(far_load), .i_word(far_word),
    .o_miso(miso), .o_got(far_got));

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : tick
  task automatic chk16(input logic [15:0] g, input logic [15:0] e, input string what);
    compares++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
    end
  endtask : chk16
  task automatic chk1(input logic g, input logic e, input string what);
    chk16({15'h0000, g}, {15'h0000, e}, what);
  endtask : chk1
  // Pulses last one clock, then one idle clock so no strobe is set twice per step
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask : pulse
  task automatic arm(input logic [15:0] w);
    far_word = w;
    pulse(far_load);
  endtask : arm
  task automatic sw_write(input logic [15:0] d);
    wdata = d;
    pulse(wr);
  endtask : sw_write
  task automatic rd_chk(input logic [15:0] e);
    chk16(rx_data, e, "read data");
    pulse(rd);
    chk1(rx_full, 1'b0, "buffer empty after read");
  endtask : rd_chk
  task automatic wait_done;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    chk1(done, 1'b1, "done flag");
    tick(1);
    chk1(irq, irq_en, "irq line");
    pulse(flag_clr);
    tick(4);
  endtask : wait_done
  task automatic xfer(input logic [15:0] tx, input logic [15:0] slv);
    arm(slv);
    sw_write(tx);
    wait_done();
  endtask : xfer
  // Bench-made shift clock for slave mode, each level held two clocks
  task automatic slave_clocks(input int n);
    repeat (n) begin
      sck_in = 1'b1;
      tick(2);
      sck_in = 1'b0;
      tick(2);
    end
  endtask : slave_clocks
  task automatic wrap_up;
    $display("counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    tick(16);
    i_sys_rst = 1'b0;
    tick(2);
    cfg.enable = 1'b1;
    cfg.master_mode = 1'b1;
    cfg.clock_edge_sel = 1'b1;
    cfg.primary_prescale_sel = 2'h3;
    cfg.secondary_prescale_sel = 3'h7;
    cfg.clock_idle_polarity = 1'b1;
    tick(4);
    chk1(sck, 1'b1, "idle high");
    cfg.clock_idle_polarity = 1'b0;
    tick(4);
    chk1(sck, 1'b0, "idle low");
    xfer(16'h12A5, 16'h003C);
    chk16({8'h00, far_got[7:0]}, 16'h00A5, "sent byte");
    rd_chk(16'h003C);
    $display("test byte finished");
    irq_en = 1'b0;
    xfer(16'h0011, 16'h0055);
    xfer(16'h0022, 16'h0066);
    chk1(ovf, 1'b1, "overflow set");
    arm(16'h0077);
    sw_write(16'h0033);
    tick(20);
    chk1(tx_full, 1'b1, "held while overflow");
    rd_chk(16'h0055);
    chk1(ovf, 1'b0, "overflow cleared");
    wait_done();
    chk16({8'h00, far_got[7:0]}, 16'h0033, "sent after overflow");
    $display("test overflow finished");
    cfg.enable = 1'b0;
    tick(2);
    cfg.word_width_select = 1'b1;
    tick(2);
    chk1(rx_full, 1'b0, "width change clears");
    cfg.enable = 1'b1;
    tick(2);
    xfer(16'hC3A5, 16'h5AF0);
    chk16(far_got, 16'hC3A5, "sent word");
    rd_chk(16'h5AF0);
    $display("test word finished");
    arm(16'h0F0F);
    sw_write(16'h00FF);
    tick(10);
    sleep = 1'b1;
    tick(80);
    chk1(sck, 1'b0, "clock parked");
    chk1(done, 1'b0, "transfer aborted");
    chk16(rx_data, 16'h5AF0, "buffer kept");
    sleep = 1'b0;
    tick(4);
    $display("test sleep finished");
    cfg.data_out_disable = 1'b1;
    xfer(16'hAAAA, 16'h1357);
    chk1(sdo_oe_n, 1'b1, "output released");
    chk16(far_got, 16'h5555, "far end saw released line");
    rd_chk(16'h1357);
    $display("test receive_only finished");
    cfg.data_out_disable = 1'b0;
    cfg.framed_mode_enable = 1'b1;
    xfer(16'h3C5A, 16'hA5C3);
    chk1(fs_oe_n, 1'b0, "frame sync driven");
    chk16(far_got, 16'h3C5A, "framed word sent");
    rd_chk(16'hA5C3);
    $display("test framed finished");
    cfg.framed_mode_enable = 1'b0;
    cfg.master_mode = 1'b0;
    cfg.slave_select_enable = 1'b1;
    sw_write(16'hFFFF);
    chk1(sdo_oe_n, 1'b1, "released while deselected");
    ss_n = 1'b0;
    slave_clocks(3);
    ss_n = 1'b1;
    tick(2);
    chk1(sdo_oe_n, 1'b1, "released after deselect");
    arm(16'h9C3E);
    sw_write(16'h6D21);
    ss_n = 1'b0;
    tick(2);
    chk1(sdo_oe_n, 1'b0, "driven while selected");
    slave_clocks(16);
    wait_done();
    chk16(far_got, 16'h6D21, "slave word from top bit");
    slave_clocks(16);
    chk1(ovf, 1'b1, "slave overflow");
    pulse(ovf_clr);
    chk1(ovf, 1'b0, "overflow written clear");
    rd_chk(16'h9C3E);
    ss_n = 1'b1;
    $display("test slave finished");
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : tb_spisp_port
